// >>> bench/compare_load_model.sv
// load on the compare pin: counts pin edges for the bench
`timescale 1ns/1ps
module compare_load_model (
  // system
  input  wire logic       clk,
  input  wire logic       rst_b,
  // pin
  input  wire logic       compare_output_pin,
  // observation
  output logic      [7:0] rise_count,
  output logic      [7:0] fall_count
);
  logic pin_last;

  // sampled on the clock, so a one-cycle glitch still counts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_last   <= 1'b0;
      rise_count <= 8'h00;
      fall_count <= 8'h00;
    end else begin
      pin_last <= compare_output_pin;
      if (compare_output_pin && !pin_last) rise_count <= rise_count + 8'h01;
      if (!compare_output_pin && pin_last) fall_count <= fall_count + 8'h01;
    end
  end
endmodule

// >>> bench/test_output_compare_channel.sv
// self-checking bench for the output compare channel
`timescale 1ns/1ps
module test_output_compare_channel;
  // far from every compare value, so a parked timer never matches
  localparam logic [15:0] PARK = 16'hfff0;
  logic        clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        cpu_idle, gpio_level, shared_fault_input, compare_output_pin, irq;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [3:0]  wb_sel_i;
  logic [15:0] timer2_value, timer3_value, prim, sec;
  logic [7:0]  rises, falls, f0, r0;
  logic [2:0]  order [5];
  logic [1:0]  exp2;
  logic        tsel, pin0;
  integer      seed, n_errors, tests_run;

  output_compare_channel #(.TIMER_WIDTH(16), .CHANNEL_INDEX(1)) dut_u (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer2_value(timer2_value), .timer3_value(timer3_value),
    .cpu_idle(cpu_idle), .gpio_level(gpio_level), .shared_fault_input(shared_fault_input),
    .compare_output_pin(compare_output_pin), .irq(irq));

  compare_load_model load_u (.clk(clk), .rst_b(rst_b), .compare_output_pin(compare_output_pin),
    .rise_count(rises), .fall_count(falls));

  always #5 clk = ~clk;

  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {24'h000000, a};
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk);
      #1;
      n = n + 1;
    end while (wb_ack_o !== 1'b1);
    check("ack latency", 32'h1, n);
    @(posedge clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // pin is checked one cycle behind the timer it reacts to
  task automatic sweep(input int top, input logic pwm);
    for (int k = 0; k <= top; k++) begin
      @(posedge clk);
      timer2_value <= tsel ? PARK : 16'(k);
      timer3_value <= tsel ? 16'(k) : PARK;
      #1;
      if (pwm && k > 0) check("pwm pin", {31'h0, (k - 1) < sec}, {31'h0, compare_output_pin});
    end
    @(posedge clk);
    timer2_value <= PARK;
    timer3_value <= PARK;
    settle(2);
  endtask

  function automatic logic [1:0] expect_sweep(input logic [2:0] m, input logic init, input int s);
    case (m)
      3'h1: return {1'b1, s == 1};
      3'h2: return {1'b0, s == 1};
      3'h3: return {init ^ (s == 1), 1'b1};
      3'h4: return {1'b0, s == 1};
      default: return 2'h1;
    endcase
  endfunction

  function automatic logic first_pin(input logic [2:0] m, input logic prev);
    case (m)
      3'h2: return 1'b1;
      3'h3: return prev;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    #200000;
    n_errors = n_errors + 1;
    stop_test;
  end

  initial begin
    seed = 53826;
    n_errors = 0;
    tests_run = 0;
    clk = 1'b0;
    rst_b = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    timer2_value = PARK;
    timer3_value = PARK;
    cpu_idle = 1'b0;
    gpio_level = 1'b0;
    shared_fault_input = 1'b1;
    tsel = 1'b0;
    pin0 = 1'b0;
    order = '{3'h2, 3'h1, 3'h3, 3'h4, 3'h5};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdr(output_compare_pkg::CTRL_OFFSET);
    check("control reset", 32'h0, rd);
    wr(output_compare_pkg::CTRL_OFFSET, 32'hffffffff);
    rdr(output_compare_pkg::CTRL_OFFSET);
    check("control bits", 32'h200f, rd);
    bus(1'b1, output_compare_pkg::CTRL_OFFSET, 32'h0, 4'h2);
    rdr(output_compare_pkg::CTRL_OFFSET);
    check("control lane", 32'h000f, rd);
    wr(8'h20, 32'hffffffff);
    rdr(8'h20);
    check("unmapped", 32'h0, rd);
    wr(output_compare_pkg::IRQ_ENABLE_OFFSET, 32'hffffffff);
    rdr(output_compare_pkg::IRQ_ENABLE_OFFSET);
    check("enable", 32'h3, rd);
    rdr(output_compare_pkg::IRQ_CLEAR_OFFSET);
    check("clear reads", 32'h0, rd);
    wr(output_compare_pkg::CTRL_OFFSET, 32'h0);
    for (int i = 0; i < 4; i++) begin
      gpio_level <= 1'($random(seed));
      settle(2);
      check("gpio pin", {31'h0, gpio_level}, {31'h0, compare_output_pin});
    end
    prim = 16'h0005;
    wr(output_compare_pkg::PRIMARY_OFFSET, {16'h0, prim});
    wr(output_compare_pkg::IRQ_CLEAR_OFFSET, 32'h3);
    sweep(8, 1'b0);
    rdr(output_compare_pkg::IRQ_STATUS_OFFSET);
    check("disabled status", 32'h0, rd);
    for (int i = 0; i < 5; i++) begin
      tsel = 1'($random(seed));
      cpu_idle <= 1'($random(seed));
      prim = 16'h0004 + 16'($unsigned($random(seed)) % 16);
      sec = prim + 16'h0003;
      wr(output_compare_pkg::PRIMARY_OFFSET, {16'h0, prim});
      wr(output_compare_pkg::SECONDARY_OFFSET, {16'h0, sec});
      wr(output_compare_pkg::CTRL_OFFSET, {28'h0, tsel, order[i]});
      wr(output_compare_pkg::IRQ_CLEAR_OFFSET, 32'h3);
      pin0 = first_pin(order[i], pin0);
      check("initial pin", {31'h0, pin0}, {31'h0, compare_output_pin});
      for (int s = 1; s <= 2; s++) begin
        f0 = falls;
        sweep(int'(sec) + 2, 1'b0);
        exp2 = expect_sweep(order[i], pin0, s);
        check("pin after match", {31'h0, exp2[1]}, {31'h0, compare_output_pin});
        check("irq", {31'h0, exp2[0]}, {31'h0, irq});
        rdr(output_compare_pkg::IRQ_STATUS_OFFSET);
        check("status", {31'h0, exp2[0]}, rd);
        if (order[i] > 3'h3) check("pulse falls", {31'h0, exp2[0]}, 32'(falls - f0));
        if (s == 2) wr(output_compare_pkg::IRQ_ENABLE_OFFSET, 32'h0);
        check("masked irq", {31'h0, exp2[0] && s == 1}, {31'h0, irq});
        wr(output_compare_pkg::IRQ_ENABLE_OFFSET, 32'h3);
        wr(output_compare_pkg::IRQ_CLEAR_OFFSET, 32'h1);
        check("irq cleared", 32'h0, {31'h0, irq});
      end
      pin0 = exp2[1];
    end
    // idle halt: matches seen while halted are lost, not deferred
    cpu_idle <= 1'b1;
    wr(output_compare_pkg::CTRL_OFFSET, {18'h0, 1'b1, 9'h0, tsel, 3'h1});
    sweep(int'(sec) + 2, 1'b0);
    check("halted pin", 32'h0, {31'h0, compare_output_pin});
    rdr(output_compare_pkg::IRQ_STATUS_OFFSET);
    check("halted status", 32'h0, rd);
    cpu_idle <= 1'b0;
    sweep(int'(sec) + 2, 1'b0);
    check("resumed pin", 32'h1, {31'h0, compare_output_pin});
    for (int i = 0; i < 3; i++) begin
      prim = (i == 0) ? 16'h0000 : 16'h0007;
      sec = (i == 2) ? 16'h0000 : 16'h0001 + 16'($unsigned($random(seed)) % 16);
      wr(output_compare_pkg::IRQ_CLEAR_OFFSET, 32'h3);
      wr(output_compare_pkg::PRIMARY_OFFSET, {16'h0, prim});
      wr(output_compare_pkg::SECONDARY_OFFSET, {16'h0, sec});
      wr(output_compare_pkg::CTRL_OFFSET, {28'h0, tsel, 3'h6});
      check("pwm start", {31'h0, prim != 16'h0}, {31'h0, compare_output_pin});
      sweep(20, 1'b1);
      rdr(output_compare_pkg::IRQ_STATUS_OFFSET);
      check("pwm status", 32'h0, rd);
    end
    sec = 16'h0009;
    wr(output_compare_pkg::SECONDARY_OFFSET, {16'h0, sec});
    wr(output_compare_pkg::CTRL_OFFSET, {28'h0, tsel, 3'h7});
    sweep(20, 1'b1);
    shared_fault_input <= 1'b0;
    settle(4);
    r0 = rises;
    sweep(20, 1'b0);
    check("fault pin", 32'h0, {31'h0, compare_output_pin});
    check("fault rises", {24'h0, r0}, {24'h0, rises});
    rdr(output_compare_pkg::IRQ_STATUS_OFFSET);
    check("fault status", 32'h2, rd);
    check("fault irq", 32'h1, {31'h0, irq});
    wr(output_compare_pkg::CTRL_OFFSET, {28'h0, tsel, 3'h7});
    check("fault pin on rewrite", 32'h0, {31'h0, compare_output_pin});
    shared_fault_input <= 1'b1;
    settle(4);
    rdr(output_compare_pkg::CTRL_OFFSET);
    check("fault flag held", {27'h0, 1'b1, tsel, 3'h7}, rd);
    wr(output_compare_pkg::CTRL_OFFSET, {28'h0, tsel, 3'h7});
    rdr(output_compare_pkg::CTRL_OFFSET);
    check("fault flag cleared", {28'h0, tsel, 3'h7}, rd);
    stop_test;
  end
endmodule

// >>> design/fault_input_sync.sv
// two-stage synchroniser and falling-edge detector for the shared fault pin
`timescale 1ns/1ps
module fault_input_sync (
  // system
  input  wire logic clk,
  input  wire logic rst_b,
  // pin side
  input  wire logic fault_pin,
  // synchronous side
  output logic      fault_level,
  output logic      fault_fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // idle level of the pin is high, so reset to high avoids a false edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= fault_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign fault_level = sync_reg;
  assign fault_fall  = last_reg & ~sync_reg;

endmodule

// >>> design/output_compare_channel.sv
// output compare channel with wishbone registers, eight pin modes and interrupts
// Operation
// - mode zero disables the channel; pin follows gpio level, no compare interrupt
// - active-low one-shot starts pin low, match forces high, interrupt on rise
// - active-high one-shot starts pin high, match forces low, interrupt on fall
// - toggle keeps current level, inverts on each match, interrupt on both edges
// - delayed one-shot starts low, makes one pulse, interrupt on its fall
// - continuous pulse starts low, repeats pulses, interrupt on every falling edge
// - plain pwm starts pin at primary nonzero, never interrupts
// - fault pwm honours fault input; low channels interrupt on fault falling edge
// - fault flag set by hardware on fault, cleared only by hardware
// - time base select one picks timer three, zero picks timer two
// - idle halt select one freezes the pin and interrupt events during cpu idle
// - unimplemented control bits always read zero
// - selected timer equal to a compare value changes the pin
`timescale 1ns/1ps
module output_compare_channel #(
  parameter int TIMER_WIDTH   = 16,
  parameter int CHANNEL_INDEX = 1
) (
  // system
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [31:0]            wb_adr_i,
  input  wire logic [31:0]            wb_dat_i,
  input  wire logic [3:0]             wb_sel_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // time bases and chip state
  input  wire logic [TIMER_WIDTH-1:0] timer2_value,
  input  wire logic [TIMER_WIDTH-1:0] timer3_value,
  input  wire logic                   cpu_idle,
  input  wire logic                   gpio_level,
  // pins
  input  wire logic                   shared_fault_input,
  output logic                        compare_output_pin,
  // interrupt
  output logic                        irq
);

  localparam int PAD = 32 - TIMER_WIDTH;
  localparam int IRQ_BITS_W = output_compare_pkg::IRQ_BITS;

  initial begin
    if (TIMER_WIDTH < 2 || TIMER_WIDTH > 16) begin
      $error("TIMER_WIDTH must lie between 2 and 16");
    end
    if (CHANNEL_INDEX < 1) begin
      $error("CHANNEL_INDEX must be one or more");
    end
  end

  function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  lanes);
    logic [31:0] merged;
    merged = old_word;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        merged[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return merged;
  endfunction

  // registers
  logic [15:0]            ctrl_reg;
  logic [TIMER_WIDTH-1:0] primary_reg;
  logic [TIMER_WIDTH-1:0] secondary_reg;
  logic [TIMER_WIDTH-1:0] duty_reg;
  logic [IRQ_BITS_W-1:0]  status_reg;
  logic [IRQ_BITS_W-1:0]  enable_reg;
  logic                   fault_flag_reg;
  logic                   pin_reg;
  logic                   done_reg;
  logic                   pri_seen_reg;
  logic                   sec_seen_reg;
  logic                   duty_seen_reg;
  logic                   zero_seen_reg;
  logic                   ack_reg;
  logic [31:0]            dat_reg;

  // bus decode
  wire                                 bus_req     = wb_cyc_i & wb_stb_i;
  wire                                 bus_commit  = bus_req & ack_reg;
  wire [output_compare_pkg::ADDR_DECODE_BITS-1:0] bus_addr =
    wb_adr_i[output_compare_pkg::ADDR_DECODE_BITS-1:0];
  wire                                 wr_commit   = bus_commit & wb_we_i;
  wire                                 ctrl_wr     = wr_commit & (bus_addr == output_compare_pkg::CTRL_OFFSET);
  wire                                 primary_wr  = wr_commit & (bus_addr == output_compare_pkg::PRIMARY_OFFSET);
  wire                                 second_wr   = wr_commit & (bus_addr == output_compare_pkg::SECONDARY_OFFSET);
  wire                                 clear_wr    = wr_commit & (bus_addr == output_compare_pkg::IRQ_CLEAR_OFFSET);
  wire                                 enable_wr   = wr_commit & (bus_addr == output_compare_pkg::IRQ_ENABLE_OFFSET);

  wire [31:0] ctrl_merged = lane_merge({16'h0000, ctrl_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] pri_merged  = lane_merge({{PAD{1'b0}}, primary_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] sec_merged  = lane_merge({{PAD{1'b0}}, secondary_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] en_merged   = lane_merge({30'h0, enable_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] clr_merged  = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

  wire [15:0] ctrl_next = (ctrl_merged[15:0] & output_compare_pkg::CTRL_WRITE_MASK);
  wire [2:0]  new_mode  = ctrl_next[output_compare_pkg::CTRL_MODE_MSB:output_compare_pkg::CTRL_MODE_LSB];

  // control fields
  wire [2:0] mode_reg  = ctrl_reg[output_compare_pkg::CTRL_MODE_MSB:output_compare_pkg::CTRL_MODE_LSB];
  wire       tsel      = ctrl_reg[output_compare_pkg::CTRL_TSEL_BIT];
  wire       idle_halt = ctrl_reg[output_compare_pkg::CTRL_IDLE_BIT];
  wire       halted    = idle_halt & cpu_idle;

  // fault pin
  logic fault_level;
  logic fault_fall;

  fault_input_sync fault_sync_inst (
    .clk         (clk),
    .rst_b       (rst_b),
    .fault_pin   (shared_fault_input),
    .fault_level (fault_level),
    .fault_fall  (fault_fall)
  );

  // compare against the selected time base; act once per match
  wire [TIMER_WIDTH-1:0] time_base = tsel ? timer3_value : timer2_value;
  wire pri_eq     = (time_base == primary_reg);
  wire sec_eq     = (time_base == secondary_reg);
  wire duty_eq    = (time_base == duty_reg);
  wire zero_eq    = (time_base == '0);
  wire pri_hit    = pri_eq & ~pri_seen_reg;
  wire sec_hit    = sec_eq & ~sec_seen_reg;
  wire duty_hit   = duty_eq & ~duty_seen_reg;
  wire period_go  = zero_eq & ~zero_seen_reg;
  wire pwm_mode   = (mode_reg == output_compare_pkg::MODE_PWM_PLAIN) |
                    (mode_reg == output_compare_pkg::MODE_PWM_FAULT);
  wire fault_mode = (mode_reg == output_compare_pkg::MODE_PWM_FAULT);
  wire fault_on   = fault_mode & ~fault_level;
  wire fault_irq_ok = (CHANNEL_INDEX <= output_compare_pkg::FAULT_IRQ_LAST_CHANNEL);
  wire fault_event  = fault_mode & fault_fall & fault_irq_ok & ~halted;

  // pin sequencer
  logic pin_next;
  logic done_next;
  logic cmp_event;

  always_comb begin
    pin_next  = pin_reg;
    done_next = done_reg;
    cmp_event = 1'b0;
    if (ctrl_wr) begin
      done_next = 1'b0;
      case (new_mode)
        output_compare_pkg::MODE_OFF:       pin_next = gpio_level;
        output_compare_pkg::MODE_ONE_LOW:   pin_next = 1'b0;
        output_compare_pkg::MODE_ONE_HIGH:  pin_next = 1'b1;
        output_compare_pkg::MODE_TOGGLE:    pin_next = pin_reg;
        output_compare_pkg::MODE_DELAYED,
        output_compare_pkg::MODE_CONTINUE:  pin_next = 1'b0;
        default:                            pin_next = (primary_reg != '0) &
          ~((new_mode == output_compare_pkg::MODE_PWM_FAULT) & ~fault_level);
      endcase
    end else if (!halted) begin
      case (mode_reg)
        output_compare_pkg::MODE_OFF: begin
          pin_next = gpio_level;
        end
        output_compare_pkg::MODE_ONE_LOW: begin
          if (pri_hit && !done_reg) begin
            pin_next  = 1'b1;
            done_next = 1'b1;
            cmp_event = 1'b1;
          end
        end
        output_compare_pkg::MODE_ONE_HIGH: begin
          if (pri_hit && !done_reg) begin
            pin_next  = 1'b0;
            done_next = 1'b1;
            cmp_event = 1'b1;
          end
        end
        output_compare_pkg::MODE_TOGGLE: begin
          if (pri_hit) begin
            pin_next  = ~pin_reg;
            cmp_event = 1'b1;
          end
        end
        output_compare_pkg::MODE_DELAYED,
        output_compare_pkg::MODE_CONTINUE: begin
          if (!done_reg) begin
            if (sec_hit && pin_reg) begin
              pin_next  = 1'b0;
              cmp_event = 1'b1;
              done_next = (mode_reg == output_compare_pkg::MODE_DELAYED);
            end else if (pri_hit) begin
              pin_next = 1'b1;
            end
          end
        end
        default: begin
          // pwm: fault first, then period start, then duty match
          if (fault_on) begin
            pin_next = 1'b0;
          end else if (period_go) begin
            pin_next = (secondary_reg != '0);
          end else if (duty_hit) begin
            pin_next = 1'b0;
          end
        end
      endcase
    end
  end

  // events set sticky status, set wins over clear
  wire [IRQ_BITS_W-1:0] event_bits  = {fault_event, cmp_event};
  wire [IRQ_BITS_W-1:0] clear_bits  = clear_wr ? clr_merged[IRQ_BITS_W-1:0] : '0;
  wire [IRQ_BITS_W-1:0] status_next = (status_reg & ~clear_bits) | event_bits;

  // flag cleared by hardware only: on a control rewrite once the fault pin is back high
  wire fault_flag_next = (fault_flag_reg & ~(ctrl_wr & fault_level)) | fault_on;

  // read mux; fault flag is the only hardware bit in the control word
  wire [15:0] ctrl_view = ctrl_reg |
                          (16'h0001 << output_compare_pkg::CTRL_FAULT_BIT) & {16{fault_flag_reg}};
  wire [31:0] read_word =
    (bus_addr == output_compare_pkg::CTRL_OFFSET)       ? {16'h0000, ctrl_view} :
    (bus_addr == output_compare_pkg::PRIMARY_OFFSET)    ? {{PAD{1'b0}}, primary_reg} :
    (bus_addr == output_compare_pkg::SECONDARY_OFFSET)  ? {{PAD{1'b0}}, secondary_reg} :
    (bus_addr == output_compare_pkg::IRQ_STATUS_OFFSET) ? {30'h0, status_reg} :
    (bus_addr == output_compare_pkg::IRQ_ENABLE_OFFSET) ? {30'h0, enable_reg} :
                                                          32'h0000_0000;

  // bus handshake: one wait state, ack for one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      dat_reg <= (bus_req & ~ack_reg & ~wb_we_i) ? read_word : 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg      <= output_compare_pkg::CTRL_RESET;
      primary_reg   <= '0;
      secondary_reg <= '0;
      enable_reg    <= output_compare_pkg::IRQ_RESET;
      status_reg    <= output_compare_pkg::IRQ_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= ctrl_next;
      end
      if (primary_wr) begin
        primary_reg <= pri_merged[TIMER_WIDTH-1:0];
      end
      if (second_wr) begin
        secondary_reg <= sec_merged[TIMER_WIDTH-1:0];
      end
      if (enable_wr) begin
        enable_reg <= en_merged[IRQ_BITS_W-1:0];
      end
      status_reg <= status_next;
    end
  end

  // channel state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_reg        <= 1'b0;
      done_reg       <= 1'b0;
      fault_flag_reg <= 1'b0;
      duty_reg       <= '0;
      pri_seen_reg   <= 1'b0;
      sec_seen_reg   <= 1'b0;
      duty_seen_reg  <= 1'b0;
      zero_seen_reg  <= 1'b0;
    end else begin
      pin_reg        <= pin_next;
      done_reg       <= done_next;
      fault_flag_reg <= fault_flag_next;
      pri_seen_reg   <= pri_eq;
      sec_seen_reg   <= sec_eq;
      duty_seen_reg  <= duty_eq;
      zero_seen_reg  <= zero_eq;
      if (ctrl_wr || (pwm_mode && period_go && !halted)) begin
        duty_reg <= secondary_reg;
      end
    end
  end

  assign compare_output_pin = pin_reg;
  assign wb_ack_o           = ack_reg;
  assign wb_dat_o           = dat_reg;
  assign irq                = |(status_reg & enable_reg);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_off_follows_gpio: assert property (
    (mode_reg == output_compare_pkg::MODE_OFF && !ctrl_wr && !halted)
      |=> (pin_reg == $past(gpio_level)) && !status_reg[output_compare_pkg::IRQ_COMPARE] ||
          $past(status_reg[output_compare_pkg::IRQ_COMPARE]))
    else $error("disabled channel did not follow gpio or raised compare event");

  a_low_shot_rise: assert property (
    (mode_reg == output_compare_pkg::MODE_ONE_LOW && pri_hit && !done_reg && !halted && !ctrl_wr)
      |=> pin_reg && done_reg && status_reg[output_compare_pkg::IRQ_COMPARE])
    else $error("low one-shot did not rise with interrupt on match");

  a_high_shot_fall: assert property (
    (mode_reg == output_compare_pkg::MODE_ONE_HIGH && pri_hit && !done_reg && !halted && !ctrl_wr)
      |=> !pin_reg && status_reg[output_compare_pkg::IRQ_COMPARE])
    else $error("high one-shot did not fall with interrupt on match");

  a_toggle_flips: assert property (
    (mode_reg == output_compare_pkg::MODE_TOGGLE && pri_hit && !halted && !ctrl_wr)
      |=> (pin_reg != $past(pin_reg)) && status_reg[output_compare_pkg::IRQ_COMPARE])
    else $error("toggle mode did not invert pin on match");

  a_delayed_single: assert property (
    (mode_reg == output_compare_pkg::MODE_DELAYED && done_reg && !ctrl_wr) [*2]
      |-> !pin_reg)
    else $error("delayed one-shot produced a second pulse");

  a_pulse_fall_irq: assert property (
    (mode_reg == output_compare_pkg::MODE_CONTINUE && !ctrl_wr && pin_reg && !pin_next)
      |=> status_reg[output_compare_pkg::IRQ_COMPARE])
    else $error("continuous pulse fall without interrupt");

  a_pwm_no_irq: assert property (
    (mode_reg == output_compare_pkg::MODE_PWM_PLAIN) |-> !cmp_event && !fault_event)
    else $error("plain pwm raised an interrupt");

  a_fault_drives_low: assert property (
    (fault_on && !ctrl_wr && !halted) |=> !pin_reg && fault_flag_reg)
    else $error("fault did not force pin low and set flag");

  a_flag_hw_clear: assert property (
    $fell(fault_flag_reg) |-> $past(ctrl_wr) && $past(fault_level))
    else $error("fault flag cleared without hardware condition");

  a_idle_freezes: assert property (
    (halted && !ctrl_wr) |=> $stable(pin_reg))
    else $error("halted channel changed its pin");

  a_reserved_zero: assert property (
    (bus_req && !ack_reg && !wb_we_i && bus_addr == output_compare_pkg::CTRL_OFFSET)
      |=> wb_ack_o && wb_dat_o[15:14] == 2'h0 && wb_dat_o[12:5] == 8'h00)
    else $error("unimplemented control bits read nonzero");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule

// >>> design/output_compare_pkg.sv
// constants for the output compare channel: register map, field layout, modes
package output_compare_pkg;

  // register byte offsets on the 32-bit bus
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] PRIMARY_OFFSET    = 8'h04;
  localparam logic [7:0] SECONDARY_OFFSET  = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0c;
  localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h10;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h14;
  localparam int         ADDR_DECODE_BITS  = 8;

  // control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MODE_MSB  = 2;
  localparam int CTRL_TSEL_BIT  = 3;
  localparam int CTRL_FAULT_BIT = 4;
  localparam int CTRL_IDLE_BIT  = 13;

  // software-writable bits of the control register
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h200f;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;

  // compare_mode_field encodings
  localparam logic [2:0] MODE_OFF       = 3'h0;
  localparam logic [2:0] MODE_ONE_LOW   = 3'h1;
  localparam logic [2:0] MODE_ONE_HIGH  = 3'h2;
  localparam logic [2:0] MODE_TOGGLE    = 3'h3;
  localparam logic [2:0] MODE_DELAYED   = 3'h4;
  localparam logic [2:0] MODE_CONTINUE  = 3'h5;
  localparam logic [2:0] MODE_PWM_PLAIN = 3'h6;
  localparam logic [2:0] MODE_PWM_FAULT = 3'h7;

  // interrupt status layout
  localparam int         IRQ_BITS       = 2;
  localparam int         IRQ_COMPARE    = 0;
  localparam int         IRQ_FAULT      = 1;
  localparam logic [1:0] IRQ_RESET      = 2'h0;

  // fault input is honoured with an interrupt only on the low channel numbers
  localparam int FAULT_IRQ_LAST_CHANNEL = 4;

endpackage
